// ==== core/vec_params.svh ====
// Register offsets, field positions, reset values and counts
`ifndef VEC_PARAMS_SVH
`define VEC_PARAMS_SVH
`define VEC_IDX_DAC_CFG 5
`define VEC_IDX_LINE_CFG 6
`define VEC_IDX_STATUS 9
`define VEC_ADDR_DAC_CFG 8'h14
`define VEC_ADDR_LINE_CFG 8'h18
`define VEC_ADDR_STATUS 8'h24
`define VEC_RST_DAC_CFG 8'h30
`define VEC_RST_LINE_CFG 8'h00
`define VEC_MASK_DAC_CFG 8'h7F
`define VEC_MASK_LINE_CFG 8'hFD
`define VEC_B_BLANK_R 3
`define VEC_B_BLANK_G 2
`define VEC_B_BLANK_B 1
`define VEC_B_INVERT 0
`define VEC_B_SWRST 7
`define VEC_B_JUMP 6
`define VEC_B_DEC 5
`define VEC_B_FREE 4
`define VEC_B_CFC_HI 3
`define VEC_B_CFC_LO 2
`define VEC_B_MAXDYN 0
`define VEC_SWRST_CYCLES 3'd4
`define VEC_AUTO_LINE_525 9'd245
`define VEC_AUTO_LINE_625 9'd330
`define VEC_Y_MIN_STD 8'h10
`define VEC_Y_MAX_STD 8'hEB
`define VEC_C_MAX_STD 8'hE0
`define VEC_EXT_MIN 8'h01
`define VEC_EXT_MAX 8'hFE
`define VEC_BLANK_Y 8'h10
`define VEC_BLANK_C 8'h80
`define VEC_DAC_BLACK 10'h040
`define VEC_CAP_FULL 2'h2
`define VEC_RESP_OKAY 2'h0
`define VEC_RESP_DECERR 2'h3
`endif

// ==== core/vec_pkg.sv ====
// Types shared by the encoder control register block
package vec_pkg;
  typedef enum logic [1:0] {CFC_REG_ONLY, CFC_SERIAL, CFC_HSYNC, CFC_BURST}
    vec_cfc_t;
  typedef enum logic [1:0] {SEL_NONE, SEL_DAC, SEL_LINE, SEL_STAT} vec_sel_t;
  typedef enum logic [1:0] {LN_IDLE, LN_ARMED, LN_ACTIVE} vec_line_st_t;
  typedef struct packed {
    vec_line_st_t st;
    logic insertPulse;
    logic skipPulse;
    logic jumpPulse;
    logic [8:0] jumpTarget;
  } vec_line_state_t;
  typedef struct packed {
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [7:0] wData;
    logic wEn;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [7:0] dacCfg;
    logic [7:0] lineCfg;
    logic [2:0] swCnt;
    logic hokPrevErr;
    logic hok;
    logic [2:0] fieldCnt;
    logic [1:0] capPend1;
    logic [1:0] capPend2;
    logic [23:0] incr;
    logic [23:0] serHold;
    logic serPend;
    logic [7:0] yOut;
    logic [7:0] cOut;
    logic [9:0] dacR;
    logic [9:0] dacG;
    logic [9:0] dacB;
  } vec_regs_state_t;
endpackage : vec_pkg

// ==== core/vec_line_if.sv ====
// Link between register logic and line sequencer
interface vec_line_if;
  logic autoReq;
  logic decSel;
  logic freeJump;
  logic std625;
  logic frameStart;
  logic lineEnd;
  logic field2;
  logic [8:0] lineNum;
  logic [8:0] refLine;
  logic [8:0] targLine;
  logic done;
  logic busy;
  logic insertPulse;
  logic skipPulse;
  logic jumpPulse;
  logic [8:0] jumpTarget;
  modport regs (output autoReq, decSel, freeJump, std625, frameStart, lineEnd,
    field2, lineNum, refLine, targLine, input done, busy, insertPulse,
    skipPulse, jumpPulse, jumpTarget);
  modport seq (input autoReq, decSel, freeJump, std625, frameStart, lineEnd,
    field2, lineNum, refLine, targLine, output done, busy, insertPulse,
    skipPulse, jumpPulse, jumpTarget);
endinterface : vec_line_if

// ==== core/vec_line_seq.sv ====
// Line insert, skip and jump sequencer
`include "vec_params.svh"
module vec_line_seq (
  input wire logic ref_clk,
  input wire logic seqRstN,
  vec_line_if.seq lineIf
);
  import vec_pkg::*;
  vec_line_state_t q;
  vec_line_state_t d;
  logic [8:0] autoLine;

  assign autoLine = lineIf.std625 ? `VEC_AUTO_LINE_625 : `VEC_AUTO_LINE_525;
  // Frame end closes an automatic request
  assign lineIf.done = (q.st == LN_ACTIVE) && lineIf.frameStart;
  assign lineIf.busy = (q.st != LN_IDLE);
  assign lineIf.insertPulse = q.insertPulse;
  assign lineIf.skipPulse = q.skipPulse;
  assign lineIf.jumpPulse = q.jumpPulse;
  assign lineIf.jumpTarget = q.jumpTarget;

  always_comb begin
    d = q;
    d.insertPulse = 1'b0;
    d.skipPulse = 1'b0;
    d.jumpPulse = 1'b0;
    unique case (q.st)
      LN_IDLE: begin
        if (lineIf.autoReq) begin
          d.st = LN_ARMED;
        end
      end
      LN_ARMED: begin
        if (lineIf.frameStart) begin
          d.st = LN_ACTIVE;
        end
      end
      LN_ACTIVE: begin
        if (lineIf.frameStart) begin
          d.st = LN_IDLE;
        end else if (lineIf.lineEnd && lineIf.field2 &&
                     lineIf.lineNum == autoLine) begin
          d.insertPulse = !lineIf.decSel;
          d.skipPulse = lineIf.decSel;
        end
      end
    endcase
    // Manual mode jumps in both fields, line registers ignored in auto
    if (lineIf.freeJump && !lineIf.autoReq && lineIf.lineEnd &&
        lineIf.lineNum == lineIf.refLine) begin
      d.jumpPulse = 1'b1;
      d.jumpTarget = lineIf.targLine;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!seqRstN) begin
      q <= '{st: LN_IDLE, jumpTarget: 9'h001, default: '0};
    end else begin
      q <= d;
    end
  end

  a_jump_target: assert property (
    @(posedge ref_clk) disable iff (!seqRstN)
    q.jumpPulse |-> q.jumpTarget == $past(lineIf.targLine))
    else $error("jump target differs from programmed target line");
endmodule : vec_line_seq

// ==== core/vec_regs.sv ====
// Encoder DAC, line and status registers behind an AXI4-Lite slave
`include "vec_params.svh"
module vec_regs (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [9:0] dacInR,
  input wire logic [9:0] dacInG,
  input wire logic [9:0] dacInB,
  output logic [9:0] dacOutR,
  output logic [9:0] dacOutG,
  output logic [9:0] dacOutB,
  input wire logic pixValid,
  input wire logic pixTimingWord,
  input wire logic [7:0] pixY,
  input wire logic [7:0] pixC,
  output logic [7:0] lumaOut,
  output logic [7:0] chromaOut,
  input wire logic timingWordValid,
  input wire logic timingWordErr,
  input wire logic slaveMode,
  input wire logic frameLocked,
  input wire logic fieldStart,
  input wire logic captionWrF1,
  input wire logic captionWrF2,
  input wire logic captionEncF1,
  input wire logic captionEncF2,
  input wire logic [23:0] regIncr,
  input wire logic regIncrWr,
  input wire logic [23:0] serialIncr,
  input wire logic serialLoadDone,
  input wire logic hsyncEdge,
  input wire logic burstStart,
  output logic [23:0] subcarrierIncr,
  input wire logic frameStart,
  input wire logic lineEnd,
  input wire logic field2,
  input wire logic std625,
  input wire logic [8:0] lineNum,
  input wire logic [8:0] refLine,
  input wire logic [8:0] targLine,
  output logic lineInsert,
  output logic lineSkip,
  output logic lineJump,
  output logic [8:0] jumpTarget,
  output logic softResetN
);
  import vec_pkg::*;

  localparam vec_regs_state_t RegsRst = '{
    dacCfg: `VEC_RST_DAC_CFG,
    lineCfg: `VEC_RST_LINE_CFG,
    hok: 1'b1,
    default: '0
  };

  vec_regs_state_t q;
  vec_regs_state_t d;
  vec_line_if lineIf ();
  logic [7:0] statusVal;
  logic jumping;
  logic writeNow;
  logic evtUpdate;
  vec_sel_t wrSel;
  vec_cfc_t cfcMode;

  function automatic vec_sel_t regSel(input logic [7:0] addr);
    unique case (addr)
      `VEC_ADDR_DAC_CFG: regSel = SEL_DAC;
      `VEC_ADDR_LINE_CFG: regSel = SEL_LINE;
      `VEC_ADDR_STATUS: regSel = SEL_STAT;
      default: regSel = SEL_NONE;
    endcase
  endfunction : regSel

  function automatic logic [7:0] clampCode(input logic [7:0] v,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    if (v < lo) begin
      clampCode = lo;
    end else if (v > hi) begin
      clampCode = hi;
    end else begin
      clampCode = v;
    end
  endfunction : clampCode

  function automatic logic [9:0] dacCode(input logic [9:0] v,
                                         input logic blank,
                                         input logic inv);
    logic [9:0] c;
    c = blank ? `VEC_DAC_BLACK : v;
    dacCode = inv ? ~c : c;
  endfunction : dacCode

  // Pending caption pairs, saturating at two
  function automatic logic [1:0] capNext(input logic [1:0] pend,
                                         input logic wr,
                                         input logic enc);
    capNext = pend;
    if (wr && !enc && pend != `VEC_CAP_FULL) begin
      capNext = pend + 2'h1;
    end else if (enc && !wr && pend != 2'h0) begin
      capNext = pend - 2'h1;
    end
  endfunction : capNext

  // Line sequencer hookup
  assign lineIf.autoReq = q.lineCfg[`VEC_B_JUMP] && !q.lineCfg[`VEC_B_FREE];
  assign lineIf.decSel = q.lineCfg[`VEC_B_DEC];
  assign lineIf.freeJump = q.lineCfg[`VEC_B_FREE] && !q.lineCfg[`VEC_B_JUMP];
  assign lineIf.std625 = std625;
  assign lineIf.frameStart = frameStart;
  assign lineIf.lineEnd = lineEnd;
  assign lineIf.field2 = field2;
  assign lineIf.lineNum = lineNum;
  assign lineIf.refLine = refLine;
  assign lineIf.targLine = targLine;

  // Mode 000 issues no line pulses unless a request was already armed or active
  vec_line_seq uLineSeq (
    .ref_clk(ref_clk),
    .seqRstN(rstn && softResetN),
    .lineIf(lineIf)
  );

  assign lineInsert = lineIf.insertPulse;
  assign lineSkip = lineIf.skipPulse;
  assign lineJump = lineIf.jumpPulse;
  assign jumpTarget = lineIf.jumpTarget;

  assign jumping = q.lineCfg[`VEC_B_JUMP] || lineIf.busy ||
                   lineIf.freeJump;
  assign statusVal = {q.hok,
                      slaveMode && frameLocked,
                      q.capPend2 != `VEC_CAP_FULL,
                      q.capPend1 != `VEC_CAP_FULL,
                      q.fieldCnt,
                      jumping};

  assign softResetN = (q.swCnt == 3'd0);
  assign writeNow = q.awHave && q.wHave && !q.bValid;
  assign wrSel = regSel(q.awAddr);
  assign cfcMode = vec_cfc_t'(q.lineCfg[`VEC_B_CFC_HI:`VEC_B_CFC_LO]);
  assign evtUpdate = (cfcMode == CFC_HSYNC) ? hsyncEdge : burstStart;

  assign s_axi_awready = !q.awHave;
  assign s_axi_wready = !q.wHave;
  assign s_axi_bvalid = q.bValid;
  assign s_axi_bresp = q.bResp;
  assign s_axi_arready = !q.rValid;
  assign s_axi_rvalid = q.rValid;
  assign s_axi_rdata = q.rData;
  assign s_axi_rresp = q.rResp;
  assign subcarrierIncr = q.incr;
  assign lumaOut = q.yOut;
  assign chromaOut = q.cOut;
  assign dacOutR = q.dacR;
  assign dacOutG = q.dacG;
  assign dacOutB = q.dacB;

  always_comb begin
    d = q;
    // Bus channels
    if (s_axi_awvalid && !q.awHave) begin
      d.awHave = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wHave) begin
      d.wHave = 1'b1;
      d.wData = s_axi_wdata[7:0];
      d.wEn = s_axi_wstrb[0];
    end
    if (q.bValid && s_axi_bready) begin
      d.bValid = 1'b0;
    end
    if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end
    if (s_axi_arvalid && !q.rValid) begin
      d.rValid = 1'b1;
      d.rResp = `VEC_RESP_OKAY;
      unique case (regSel(s_axi_araddr))
        SEL_DAC: d.rData = {24'h000000, q.dacCfg};
        SEL_LINE: d.rData = {24'h000000, q.lineCfg};
        SEL_STAT: d.rData = {24'h000000, statusVal};
        SEL_NONE: begin
          d.rData = 32'h00000000;
          d.rResp = `VEC_RESP_DECERR;
        end
      endcase
    end
    // Hardware clears first, so a same-cycle write wins
    if (lineIf.done) begin
      d.lineCfg[`VEC_B_JUMP] = 1'b0;
    end
    if (q.swCnt != 3'd0) begin
      d.swCnt = q.swCnt - 3'd1;
    end
    if (q.swCnt == 3'd1) begin
      d.lineCfg[`VEC_B_SWRST] = 1'b0;
    end
    if (writeNow) begin
      d.awHave = 1'b0;
      d.wHave = 1'b0;
      d.bValid = 1'b1;
      d.bResp = (wrSel == SEL_NONE) ? `VEC_RESP_DECERR : `VEC_RESP_OKAY;
      if (q.wEn) begin
        unique case (wrSel)
          SEL_DAC: d.dacCfg = q.wData & `VEC_MASK_DAC_CFG;
          SEL_LINE: begin
            d.lineCfg = q.wData & `VEC_MASK_LINE_CFG;
            if (q.wData[`VEC_B_SWRST]) begin
              d.swCnt = `VEC_SWRST_CYCLES;
            end
          end
          SEL_STAT: d.bResp = `VEC_RESP_OKAY;
          SEL_NONE: d.bResp = `VEC_RESP_DECERR;
        endcase
      end
    end
    // Timing word check: two failures in a row drop the flag
    if (timingWordValid) begin
      d.hokPrevErr = timingWordErr;
      d.hok = !(timingWordErr && q.hokPrevErr);
    end
    if (fieldStart) begin
      d.fieldCnt = q.fieldCnt + 3'd1;
    end
    d.capPend1 = capNext(q.capPend1, captionWrF1, captionEncF1);
    d.capPend2 = capNext(q.capPend2, captionWrF2, captionEncF2);
    // Subcarrier increment update moment
    unique case (cfcMode)
      CFC_REG_ONLY: begin
        if (regIncrWr) begin
          d.incr = regIncr;
        end
      end
      CFC_SERIAL: begin
        if (serialLoadDone) begin
          d.incr = serialIncr;
        end
      end
      CFC_HSYNC, CFC_BURST: begin
        if (evtUpdate && q.serPend) begin
          d.incr = q.serHold;
          d.serPend = 1'b0;
        end
        if (serialLoadDone) begin
          d.serHold = serialIncr;
          d.serPend = 1'b1;
        end
      end
    endcase
    // Pixel input range and timing word substitution
    if (pixValid) begin
      if (pixTimingWord) begin
        d.yOut = `VEC_BLANK_Y;
        d.cOut = `VEC_BLANK_C;
      end else if (q.lineCfg[`VEC_B_MAXDYN]) begin
        d.yOut = clampCode(pixY, `VEC_EXT_MIN, `VEC_EXT_MAX);
        d.cOut = clampCode(pixC, `VEC_EXT_MIN, `VEC_EXT_MAX);
      end else begin
        d.yOut = clampCode(pixY, `VEC_Y_MIN_STD, `VEC_Y_MAX_STD);
        d.cOut = clampCode(pixC, `VEC_Y_MIN_STD, `VEC_C_MAX_STD);
      end
    end
    d.dacR = dacCode(dacInR, q.dacCfg[`VEC_B_BLANK_R],
                     q.dacCfg[`VEC_B_INVERT]);
    d.dacG = dacCode(dacInG, q.dacCfg[`VEC_B_BLANK_G],
                     q.dacCfg[`VEC_B_INVERT]);
    d.dacB = dacCode(dacInB, q.dacCfg[`VEC_B_BLANK_B],
                     q.dacCfg[`VEC_B_INVERT]);
    // Soft reset clears device state, configuration kept
    if (q.swCnt != 3'd0) begin
      d.hokPrevErr = 1'b0;
      d.hok = 1'b1;
      d.fieldCnt = 3'd0;
      d.capPend1 = 2'h0;
      d.capPend2 = 2'h0;
      d.serPend = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      q <= RegsRst;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_dac_cfg_reset: assert property (
    $rose(rstn) |-> q.dacCfg == `VEC_RST_DAC_CFG)
    else $error("DAC configuration not 30h after reset");

  a_line_cfg_reset: assert property (
    $rose(rstn) |-> q.lineCfg == `VEC_RST_LINE_CFG)
    else $error("line configuration not 00h after reset");

  a_soft_reset_len: assert property (
    $fell(softResetN) |-> (!softResetN) [*4] ##1
      (softResetN && !q.lineCfg[`VEC_B_SWRST]))
    else $error("soft reset not four cycles or bit not cleared");

  a_soft_keep_cfg: assert property (
    $fell(softResetN) |-> q.dacCfg == $past(q.dacCfg))
    else $error("soft reset disturbed DAC configuration");

  a_blank_red: assert property (
    q.dacCfg[`VEC_B_BLANK_R] && !q.dacCfg[`VEC_B_INVERT]
      && $stable(q.dacCfg) |=> dacOutR == `VEC_DAC_BLACK)
    else $error("red converter not forced to black");

  a_dac_invert: assert property (
    q.dacCfg[`VEC_B_INVERT] && !q.dacCfg[`VEC_B_BLANK_G]
      && $stable(q.dacCfg) |=> dacOutG == ~$past(dacInG))
    else $error("green converter code not inverted");

  a_timing_blank: assert property (
    pixValid && pixTimingWord |=> lumaOut == `VEC_BLANK_Y &&
      chromaOut == `VEC_BLANK_C)
    else $error("timing word not replaced by blanking");

  a_luma_range: assert property (
    pixValid && !pixTimingWord && !q.lineCfg[`VEC_B_MAXDYN]
      |=> lumaOut >= `VEC_Y_MIN_STD && lumaOut <= `VEC_Y_MAX_STD)
    else $error("luma outside standard range");

  a_caption_flag: assert property (
    q.capPend2 == `VEC_CAP_FULL && captionEncF2 && !captionWrF2
      |=> statusVal[5])
    else $error("field-2 caption flag not set after encode");

  a_field_count: assert property (
    fieldStart && softResetN |=> q.fieldCnt == $past(q.fieldCnt) + 3'd1)
    else $error("field counter did not advance");

  a_reserved_zero: assert property (
    q.lineCfg[1] == 1'b0 && q.dacCfg[7] == 1'b0)
    else $error("reserved bit reads as one");

  a_jump_clear: assert property (
    lineIf.done && !writeNow |=> !q.lineCfg[`VEC_B_JUMP])
    else $error("jump request not cleared after use");
endmodule : vec_regs

// ==== tb/vec_regs_bench.sv ====
// Self-checking bench for the encoder register block
`include "vec_params.svh"
module vec_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FS = 0, CW1 = 1, CW2 = 2, CE1 = 3, CE2 = 4, RIW = 5;
  localparam int SLD = 6, HS = 7, BU = 8, FR = 9, LE = 10, TWV = 11, PV = 12;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] dacInR = 10'h123, dacInG = 10'h2A5, dacInB = 10'h0F0;
  logic [9:0] dacOutR, dacOutG, dacOutB;
  logic [12:0] pls = 13'h0;
  logic pixTimingWord = 1'b0, timingWordErr = 1'b0;
  logic slaveMode = 1'b0, frameLocked = 1'b0;
  logic field2 = 1'b0, std625 = 1'b0;
  logic [7:0] pixY = 8'h00, pixC = 8'h00, lumaOut, chromaOut;
  logic [23:0] regIncr = 24'h0, serialIncr = 24'h0, subcarrierIncr;
  logic [8:0] lineNum = 9'h000, refLine = 9'h000, targLine = 9'h001;
  logic [8:0] jumpTarget, lastTarget = 9'h000;
  logic lineInsert, lineSkip, lineJump, softResetN;
  int mismatches = 0, totalChecks = 0, insCnt = 0, skipCnt = 0, jmpCnt = 0;
  int swLow = 0;
  logic [31:0] rdat;

  vec_regs uut (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .dacInR, .dacInG, .dacInB, .dacOutR,
    .dacOutG, .dacOutB, .pixValid(pls[PV]), .pixTimingWord, .pixY, .pixC,
    .lumaOut, .chromaOut, .timingWordValid(pls[TWV]), .timingWordErr,
    .slaveMode, .frameLocked, .fieldStart(pls[FS]), .captionWrF1(pls[CW1]),
    .captionWrF2(pls[CW2]), .captionEncF1(pls[CE1]),
    .captionEncF2(pls[CE2]), .regIncr, .regIncrWr(pls[RIW]), .serialIncr,
    .serialLoadDone(pls[SLD]), .hsyncEdge(pls[HS]), .burstStart(pls[BU]),
    .subcarrierIncr, .frameStart(pls[FR]), .lineEnd(pls[LE]), .field2,
    .std625, .lineNum, .refLine, .targLine, .lineInsert, .lineSkip,
    .lineJump, .jumpTarget, .softResetN);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // Line pulses are one cycle wide, so count them as they pass
  always @(posedge ref_clk) begin
    if (lineInsert === 1'b1) insCnt <= insCnt + 1;
    if (lineSkip === 1'b1) skipCnt <= skipCnt + 1;
    if (softResetN === 1'b0) swLow <= swLow + 1;
    if (lineJump === 1'b1) begin
      jmpCnt <= jmpCnt + 1;
      lastTarget <= jumpTarget;
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic hang;
    mismatches++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    conclude();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = `VEC_RESP_OKAY);
    int n;
    logic awT, wT, bT;
    logic [1:0] resp;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge ref_clk);
      awT = s_axi_awvalid & s_axi_awready;
      wT = s_axi_wvalid & s_axi_wready;
      bT = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge ref_clk);
      if (awT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
      if (bT) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang();
    chk({30'h0, resp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er = `VEC_RESP_OKAY);
    int n;
    logic arT, rT;
    logic [1:0] resp;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge ref_clk);
      arT = s_axi_arvalid & s_axi_arready;
      rT = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge ref_clk);
      if (arT) s_axi_arvalid <= 1'b0;
      if (rT) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang();
    chk({30'h0, resp}, {30'h0, er});
  endtask : rd

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, {24'h0, e});
  endtask : rdChk

  task automatic pulse(input int i, input int n = 1);
    repeat (n) begin
      @(posedge ref_clk);
      pls[i] <= 1'b1;
      @(posedge ref_clk);
      pls[i] <= 1'b0;
    end
  endtask : pulse

  task automatic lineAt(input logic [8:0] n, input logic f2);
    @(posedge ref_clk);
    lineNum <= n;
    field2 <= f2;
    pulse(LE);
    repeat (2) @(negedge ref_clk);
  endtask : lineAt

  task automatic pix(input logic [7:0] y, c, input logic tw,
                     input logic [7:0] ey, ec);
    @(posedge ref_clk);
    pixY <= y;
    pixC <= c;
    pixTimingWord <= tw;
    pulse(PV);
    @(negedge ref_clk);
    chk({16'h0, lumaOut, chromaOut}, {16'h0, ey, ec});
  endtask : pix

  task automatic incrChk(input int i, input logic [23:0] e);
    pulse(i);
    @(negedge ref_clk);
    chk({8'h0, subcarrierIncr}, {8'h0, e});
  endtask : incrChk

  initial begin
    logic [9:0] r, g, b;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    rdChk(`VEC_ADDR_DAC_CFG, `VEC_RST_DAC_CFG);
    rdChk(`VEC_ADDR_LINE_CFG, `VEC_RST_LINE_CFG);
    rdChk(`VEC_ADDR_STATUS, 8'hB0);
    wr(`VEC_ADDR_STATUS, 8'h4F);
    rdChk(`VEC_ADDR_STATUS, 8'hB0);
    wr(8'h40, 8'h11, `VEC_RESP_DECERR);
    rd(8'h40, rdat, `VEC_RESP_DECERR);
    chk(rdat, 32'h0);
    wr(`VEC_ADDR_LINE_CFG, 8'h02);
    rdChk(`VEC_ADDR_LINE_CFG, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(`VEC_ADDR_DAC_CFG, 8'h01 << i);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      r = (i == 3) ? `VEC_DAC_BLACK : (i == 0) ? ~dacInR : dacInR;
      g = (i == 2) ? `VEC_DAC_BLACK : (i == 0) ? ~dacInG : dacInG;
      b = (i == 1) ? `VEC_DAC_BLACK : (i == 0) ? ~dacInB : dacInB;
      chk({2'h0, dacOutR, dacOutG, dacOutB}, {2'h0, r, g, b});
    end
    $display("test converter done");
    pix(8'h05, 8'hF0, 1'b0, 8'h10, 8'hE0);
    pix(8'hF5, 8'h05, 1'b0, 8'hEB, 8'h10);
    wr(`VEC_ADDR_LINE_CFG, 8'h01);
    pix(8'h00, 8'hFF, 1'b0, 8'h01, 8'hFE);
    pix(8'hEE, 8'hE5, 1'b0, 8'hEE, 8'hE5);
    pix(8'hFF, 8'h00, 1'b1, 8'h10, 8'h80);
    $display("test range done");
    pulse(CW2, 2);
    rdChk(`VEC_ADDR_STATUS, 8'h90);
    pulse(CE2);
    rdChk(`VEC_ADDR_STATUS, 8'hB0);
    pulse(CW1, 2);
    rdChk(`VEC_ADDR_STATUS, 8'hA0);
    pulse(CE1);
    pulse(FS, 3);
    rdChk(`VEC_ADDR_STATUS, 8'hB6);
    pulse(FS, 5);
    rdChk(`VEC_ADDR_STATUS, 8'hB0);
    timingWordErr <= 1'b1;
    pulse(TWV);
    rdChk(`VEC_ADDR_STATUS, 8'hB0);
    pulse(TWV);
    rdChk(`VEC_ADDR_STATUS, 8'h30);
    timingWordErr <= 1'b0;
    pulse(TWV);
    slaveMode <= 1'b1;
    frameLocked <= 1'b1;
    rdChk(`VEC_ADDR_STATUS, 8'hF0);
    slaveMode <= 1'b0;
    rdChk(`VEC_ADDR_STATUS, 8'hB0);
    $display("test status done");
    regIncr <= 24'h123456;
    serialIncr <= 24'hABCDEF;
    incrChk(RIW, 24'h123456);
    incrChk(SLD, 24'h123456);
    wr(`VEC_ADDR_LINE_CFG, 8'h04);
    incrChk(SLD, 24'hABCDEF);
    wr(`VEC_ADDR_LINE_CFG, 8'h08);
    serialIncr <= 24'h111111;
    incrChk(SLD, 24'hABCDEF);
    incrChk(HS, 24'h111111);
    wr(`VEC_ADDR_LINE_CFG, 8'h0C);
    serialIncr <= 24'h222222;
    incrChk(SLD, 24'h111111);
    incrChk(BU, 24'h222222);
    $display("test subcarrier done");
    wr(`VEC_ADDR_LINE_CFG, 8'h00);
    lineAt(9'd245, 1'b1);
    chk(32'(insCnt + skipCnt + jmpCnt), 32'h0);
    wr(`VEC_ADDR_LINE_CFG, 8'h40);
    rdChk(`VEC_ADDR_STATUS, 8'hB1);
    pulse(FR);
    lineAt(9'd244, 1'b1);
    lineAt(9'd245, 1'b0);
    chk(32'(insCnt), 32'h0);
    lineAt(9'd245, 1'b1);
    chk(32'(insCnt), 32'h1);
    pulse(FR);
    rdChk(`VEC_ADDR_LINE_CFG, 8'h00);
    rdChk(`VEC_ADDR_STATUS, 8'hB0);
    std625 <= 1'b1;
    wr(`VEC_ADDR_LINE_CFG, 8'h60);
    pulse(FR);
    lineAt(9'd330, 1'b1);
    chk(32'(skipCnt), 32'h1);
    pulse(FR);
    rdChk(`VEC_ADDR_LINE_CFG, 8'h20);
    refLine <= 9'd20;
    targLine <= 9'd7;
    wr(`VEC_ADDR_LINE_CFG, 8'h10);
    lineAt(9'd19, 1'b0);
    lineAt(9'd20, 1'b0);
    chk({23'h0, lastTarget}, 32'd7);
    chk(32'(jmpCnt), 32'h1);
    rdChk(`VEC_ADDR_STATUS, 8'hB1);
    $display("test line modes done");
    pulse(FS, 2);
    pulse(CW1);
    wr(`VEC_ADDR_LINE_CFG, 8'h84);
    repeat (12) @(negedge ref_clk);
    chk(32'(swLow), 32'h4);
    rdChk(`VEC_ADDR_LINE_CFG, 8'h04);
    rdChk(`VEC_ADDR_DAC_CFG, 8'h08);
    rdChk(`VEC_ADDR_STATUS, 8'hB0);
    chk({8'h0, subcarrierIncr}, 32'h00222222);
    $display("test soft reset done");
    conclude();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    hang();
  end
endmodule : vec_regs_bench
